// ### inc/sbs_pkg.sv
package sbs_pkg;
	localparam int ADDR_W       = 20;
	localparam int LANES        = 4;
	localparam int LANE_W       = 9;
	localparam int DATA_W       = 32;
	localparam int WORD_W       = LANES * LANE_W;
	localparam int FIFO_DEPTH   = 16;
	// Sleep takes two clocks to enter and to leave
	localparam int SLEEP_CYCLES = 2;
	localparam logic [1:0] CNT_RST   = 2'h0;
	localparam logic [1:0] STEP_ONE  = 2'h1;
	localparam logic [3:0] ALL_LANES = 4'hf;
	localparam logic [3:0] NO_LANES  = 4'h0;
	// Strap reads high when left open
	localparam logic MODE_RST = 1'b1;

	typedef enum logic [2:0] {
		SBS_DESEL  = 3'b001,
		SBS_ACTIVE = 3'b010,
		SBS_SLEEP  = 3'b100
	} sbs_state_t;
endpackage

// ### rtl/sbs_fifo.sv
module sbs_fifo #(
	parameter int WIDTH = 60,
	parameter int DEPTH = 16
) (
	input  wire logic             core_clk,
	input  wire logic             sys_rst,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] store [DEPTH];
	logic [PW-1:0]    wr_ptr;
	logic [PW-1:0]    rd_ptr;
	logic [PW:0]      count;
	logic [PW:0]      next_count;
	logic             push;
	logic             pop;

	assign push     = in_valid & in_ready;
	assign pop      = out_valid & out_ready;
	assign out_data = store[rd_ptr];

	always_comb begin
		next_count = count;
		if (push & ~pop) begin
			next_count = count + 1'b1;
		end else if (pop & ~push) begin
			next_count = count - 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (push) begin
			store[wr_ptr] <= in_data;
		end
	end

	// Flags are registers so the producer sees an honest full
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			wr_ptr    <= '0;
			rd_ptr    <= '0;
			count     <= '0;
			in_ready  <= 1'b1;
			out_valid <= 1'b0;
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
			count     <= next_count;
			in_ready  <= next_count != (PW+1)'(DEPTH);
			out_valid <= next_count != '0;
		end
	end
endmodule

// ### rtl/sbs_mem.sv
module sbs_mem #(
	parameter int ADDR_W = 20,
	parameter int LANES  = 4,
	parameter int LANE_W = 9
) (
	input  wire logic                      core_clk,
	input  wire logic                      sys_rst,
	input  wire logic                      wr_en,
	input  wire logic [ADDR_W-1:0]         wr_addr,
	input  wire logic [LANES-1:0]          wr_lanes,
	input  wire logic [LANES*LANE_W-1:0]   wr_data,
	input  wire logic                      rd_en,
	input  wire logic [ADDR_W-1:0]         rd_addr,
	output logic      [LANES*LANE_W-1:0]   rd_data
);
	logic [LANES*LANE_W-1:0] cells [2**ADDR_W];

	// One lane per select: eight data bits plus their parity bit
	always_ff @(posedge core_clk) begin
		for (int i = 0; i < LANES; i++) begin
			if (wr_en && wr_lanes[i]) begin
				cells[wr_addr][i*LANE_W +: LANE_W] <= wr_data[i*LANE_W +: LANE_W];
			end
		end
	end

	// Read register is the output lane itself, so it clears with reset
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rd_data <= '0;
		end else if (rd_en) begin
			rd_data <= cells[rd_addr];
		end
	end
endmodule

// ### rtl/sbs_port.sv
module sbs_port #(
	parameter int ADDR_W     = sbs_pkg::ADDR_W,
	parameter int FIFO_DEPTH = sbs_pkg::FIFO_DEPTH
) (
	input  wire logic                       core_clk,
	input  wire logic                       sys_rst,
	input  wire logic [ADDR_W-1:0]          addr,
	input  wire logic                       chip_select_a_n,
	input  wire logic                       chip_select_b,
	input  wire logic                       chip_select_c_n,
	input  wire logic                       processor_addr_strobe_n,
	input  wire logic                       controller_addr_strobe_n,
	input  wire logic                       burst_advance_n,
	input  wire logic                       global_write_n,
	input  wire logic                       byte_write_enable_n,
	input  wire logic [sbs_pkg::LANES-1:0]  byte_lane_select_n,
	input  wire logic                       output_enable_n,
	input  wire logic                       sleep_request,
	input  wire logic                       burst_mode,
	input  wire logic [sbs_pkg::DATA_W-1:0] data_in,
	output logic      [sbs_pkg::DATA_W-1:0] data_out,
	output logic      [sbs_pkg::DATA_W-1:0] data_oe_n,
	input  wire logic [sbs_pkg::LANES-1:0]  parity_in,
	output logic      [sbs_pkg::LANES-1:0]  parity_out,
	output logic      [sbs_pkg::LANES-1:0]  parity_oe_n,
	output logic                            write_ready,
	output logic                            sleep_active
);
	localparam int FW = ADDR_W + sbs_pkg::LANES + sbs_pkg::WORD_W;

	////////////////////////////////////////////////////////////////////////////////
	// Helpers

	function automatic logic [1:0] burst_addr(input logic [1:0] start,
		input logic [1:0] step, input logic interleaved);
		burst_addr = interleaved ? (start ^ step) : 2'(start + step);
	endfunction

	function automatic logic [sbs_pkg::LANES-1:0] lane_mask(input logic gw_n,
		input logic bwe_n, input logic [sbs_pkg::LANES-1:0] sel_n);
		if (!gw_n) begin
			lane_mask = sbs_pkg::ALL_LANES;
		end else if (!bwe_n) begin
			lane_mask = ~sel_n;
		end else begin
			lane_mask = sbs_pkg::NO_LANES;
		end
	endfunction

	// Data and parity packed per lane: parity above its byte
	function automatic logic [sbs_pkg::WORD_W-1:0] pack_word(
		input logic [sbs_pkg::DATA_W-1:0] d, input logic [sbs_pkg::LANES-1:0] p);
		for (int i = 0; i < sbs_pkg::LANES; i++) begin
			pack_word[i*sbs_pkg::LANE_W +: sbs_pkg::LANE_W] = {p[i], d[i*8 +: 8]};
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Signals

	sbs_pkg::sbs_state_t      state;
	sbs_pkg::sbs_state_t      next_state;
	logic [ADDR_W-1:0]        base_addr;
	logic [1:0]               step;
	logic [1:0]               next_step;
	logic                     interleaved;
	logic                     strap_taken;
	logic [sbs_pkg::SLEEP_CYCLES-1:0] sleep_pipe;
	logic                     strobe_p;
	logic                     strobe_c;
	logic                     load;
	logic                     selected_now;
	logic                     start;
	logic                     cont;
	logic [sbs_pkg::LANES-1:0] lanes;
	logic                     do_write;
	logic                     do_read;
	logic [ADDR_W-1:0]        use_addr;
	logic                     fifo_in_ready;
	logic                     fifo_out_valid;
	logic [FW-1:0]            fifo_out;
	logic                     drain;
	logic [sbs_pkg::WORD_W-1:0] rd_word;
	logic                     drive;

	////////////////////////////////////////////////////////////////////////////////
	// Access decode

	assign strobe_p     = ~processor_addr_strobe_n & ~chip_select_a_n;
	assign strobe_c     = ~controller_addr_strobe_n & ~strobe_p;
	assign load         = strobe_p | strobe_c;
	assign selected_now = ~chip_select_a_n & chip_select_b & ~chip_select_c_n;
	// Sleep request cancels any access in flight at once; queued writes drain until sleep is entered
	assign start        = load & selected_now & ~sleep_request;
	assign cont         = ~load & (state == sbs_pkg::SBS_ACTIVE) & ~sleep_request;
	assign lanes        = lane_mask(global_write_n, byte_write_enable_n, byte_lane_select_n);
	assign next_step    = burst_advance_n ? step : 2'(step + sbs_pkg::STEP_ONE);

	// Processor-strobe start ignores write inputs in its first clock
	assign do_write = ((start & strobe_c) | cont) & (lanes != sbs_pkg::NO_LANES)
		& fifo_in_ready;
	assign do_read  = (start & (strobe_p | lanes == sbs_pkg::NO_LANES))
		| (cont & lanes == sbs_pkg::NO_LANES);

	always_comb begin
		if (start) begin
			use_addr = addr;
		end else begin
			use_addr = {base_addr[ADDR_W-1:2],
				burst_addr(base_addr[1:0], next_step, interleaved)};
		end
	end

	always_comb begin
		next_state = state;
		unique case (state)
			sbs_pkg::SBS_DESEL, sbs_pkg::SBS_ACTIVE: begin
				if (sleep_pipe[sbs_pkg::SLEEP_CYCLES-1]) begin
					next_state = sbs_pkg::SBS_SLEEP;
				end else if (start) begin
					next_state = sbs_pkg::SBS_ACTIVE;
				end else if (load | sleep_request) begin
					next_state = sbs_pkg::SBS_DESEL;
				end
			end
			sbs_pkg::SBS_SLEEP: begin
				if (~sleep_pipe[sbs_pkg::SLEEP_CYCLES-1]) begin
					next_state = sbs_pkg::SBS_DESEL;
				end
			end
			default: next_state = sbs_pkg::SBS_DESEL;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// State

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state <= sbs_pkg::SBS_DESEL;
		end else begin
			state <= next_state;
		end
	end

	// Sleep entry and exit both take two clocks; input assumed pulled low when open
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			sleep_pipe   <= '0;
			sleep_active <= 1'b0;
		end else begin
			sleep_pipe   <= {sleep_pipe[sbs_pkg::SLEEP_CYCLES-2:0], sleep_request};
			sleep_active <= next_state == sbs_pkg::SBS_SLEEP;
		end
	end

	// Strap caught once after reset; later changes are not followed
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			interleaved <= sbs_pkg::MODE_RST;
			strap_taken <= 1'b0;
		end else if (!strap_taken) begin
			interleaved <= burst_mode;
			strap_taken <= 1'b1;
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			base_addr <= '0;
			step      <= sbs_pkg::CNT_RST;
		end else if (start) begin
			base_addr <= addr;
			step      <= sbs_pkg::CNT_RST;
		end else if (cont) begin
			step <= next_step;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Write path: captured words queue ahead of the core

	sbs_fifo #(
		.WIDTH (FW),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.core_clk  (core_clk),
		.sys_rst   (sys_rst),
		.in_valid  (do_write),
		.in_ready  (fifo_in_ready),
		.in_data   ({use_addr, lanes, pack_word(data_in, parity_in)}),
		.out_valid (fifo_out_valid),
		.out_ready (drain),
		.out_data  (fifo_out)
	);

	// Core idles in sleep; queued writes wait and are not lost
	assign drain = state != sbs_pkg::SBS_SLEEP;

	sbs_mem #(
		.ADDR_W (ADDR_W),
		.LANES  (sbs_pkg::LANES),
		.LANE_W (sbs_pkg::LANE_W)
	) u_mem (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.wr_en    (fifo_out_valid & drain),
		.wr_addr  (fifo_out[FW-1 -: ADDR_W]),
		.wr_lanes (fifo_out[sbs_pkg::WORD_W +: sbs_pkg::LANES]),
		.wr_data  (fifo_out[sbs_pkg::WORD_W-1:0]),
		.rd_en    (do_read),
		.rd_addr  (use_addr),
		.rd_data  (rd_word)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Output lanes

	// First clock out of deselect is masked; so are writes and deselect
	assign drive = do_read & ~output_enable_n
		& ~(start & state != sbs_pkg::SBS_ACTIVE);

	// Lanes come straight from the read register: another stage here would
	// leave the enable one word ahead of the data it drives
	always_comb begin
		for (int i = 0; i < sbs_pkg::LANES; i++) begin
			data_out[i*8 +: 8] = rd_word[i*sbs_pkg::LANE_W +: 8];
			parity_out[i]      = rd_word[i*sbs_pkg::LANE_W + 8];
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			data_oe_n   <= '1;
			parity_oe_n <= '1;
			write_ready <= 1'b0;
		end else begin
			data_oe_n   <= {sbs_pkg::DATA_W{~drive}};
			parity_oe_n <= {sbs_pkg::LANES{~drive}};
			write_ready <= fifo_in_ready;
		end
	end
endmodule

// ### tb/sbs_port_checker.sv
module sbs_port_checker (
	input wire logic        core_clk,
	input wire logic        sys_rst,
	input wire logic        chip_select_a_n,
	input wire logic        chip_select_b,
	input wire logic        chip_select_c_n,
	input wire logic        processor_addr_strobe_n,
	input wire logic        controller_addr_strobe_n,
	input wire logic        global_write_n,
	input wire logic        byte_write_enable_n,
	input wire logic        output_enable_n,
	input wire logic        sleep_request,
	input wire logic [31:0] data_oe_n,
	input wire logic [3:0]  parity_oe_n,
	input wire logic        sleep_active
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking dc @(posedge core_clk);
	endclocking
	default disable iff (sys_rst);
	wire sel = !chip_select_a_n && chip_select_b && !chip_select_c_n;
	wire ps = !processor_addr_strobe_n;
	wire cs = !controller_addr_strobe_n;
	wire fl = &data_oe_n;
	wire dr = !data_oe_n[0];
	wire on = !output_enable_n && !sleep_request;
	// Continue read: lane enables all agree, so bit 0 stands for the bus
	wire rd = global_write_n && byte_write_enable_n && on;
	wire desel = (ps && !chip_select_a_n || cs) && !sel;
	////////////////////////////////////////////////////////////////
	oe_high_a: assert property (output_enable_n |=> fl)
		else $error("outputs driven with enable high");
	lane_agree_a: assert property ({parity_oe_n, data_oe_n} == {36{!dr}})
		else $error("lane enables disagree");
	write_float_a: assert property (cs && !ps && sel && !global_write_n |=> fl)
		else $error("outputs driven in write");
	desel_float_a: assert property (desel |=> fl [*2])
		else $error("outputs driven after deselect");
	read_drive_a: assert property (dr && !ps && !cs && rd |=> dr)
		else $error("burst read stopped driving");
	proc_ignore_a: assert property (dr && ps && chip_select_a_n && !cs && rd |=> dr)
		else $error("strobe honoured with select off");
	both_strobe_a: assert property (dr && ps && cs && sel && !global_write_n && on |=> dr)
		else $error("controller strobe won");
	sleep_in_a: assert property (sleep_request [*3] |-> ##[0:1] sleep_active)
		else $error("sleep not entered");
	sleep_out_a: assert property (!sleep_request [*4] |-> !sleep_active)
		else $error("sleep not left");
endmodule

// ### tb/sbs_host.sv
module sbs_host (
	input  wire logic        core_clk,
	input  wire logic [31:0] data_out,
	input  wire logic [31:0] data_oe_n,
	input  wire logic [3:0]  parity_out,
	input  wire logic [3:0]  parity_oe_n,
	output logic      [5:0]  addr,
	output logic             chip_select_a_n,
	output logic             chip_select_b,
	output logic             processor_addr_strobe_n,
	output logic             controller_addr_strobe_n,
	output logic             burst_advance_n,
	output logic             global_write_n,
	output logic             byte_write_enable_n,
	output logic      [3:0]  byte_lane_select_n,
	output logic             output_enable_n,
	output logic             sleep_request,
	output logic      [31:0] data_in,
	output logic      [3:0]  parity_in
);
	timeunit 1ns;
	timeprecision 1ns;
	// Kinds: 0 deselect, 1/5 start, 2/3 write, 4 advance, 6 both, 7 select off, 8 sleep
	int          k_r = 9;
	logic [5:0]  a_r = 6'h0;
	logic [35:0] w_r = 36'h0;
	logic [3:0]  ln_r = 4'hf;
	logic        oe_r = 1'b1;
	wire         hdrv = k_r inside {2, 3, 6};
	assign addr = a_r;
	assign chip_select_a_n = k_r == 7;
	assign chip_select_b = k_r != 0;
	assign processor_addr_strobe_n = !(k_r inside {5, 6, 7});
	assign controller_addr_strobe_n = !(k_r inside {0, 1, 2, 3, 6});
	assign burst_advance_n = !(k_r inside {4, 7});
	assign global_write_n = !(k_r inside {2, 6});
	assign byte_write_enable_n = !(k_r inside {2, 3});
	assign byte_lane_select_n = ln_r;
	assign output_enable_n = oe_r;
	assign sleep_request = k_r == 8;
	// Lanes that neither side drives show the inverse, so a stale copy cannot pass
	always_comb begin
		for (int i = 0; i < 32; i++)
			data_in[i] = !data_oe_n[i] ? data_out[i] : w_r[i] ^ !hdrv;
		for (int i = 0; i < 4; i++)
			parity_in[i] = !parity_oe_n[i] ? parity_out[i] : w_r[32 + i] ^ !hdrv;
	end
	task automatic cyc(input int k, input int a, input logic [35:0] w,
		input logic [3:0] ln, input logic oe);
		@(posedge core_clk);
		k_r <= k;
		a_r <= 6'(a);
		w_r <= w;
		ln_r <= ln;
		oe_r <= oe;
	endtask
endmodule

// ### tb/sbs_port_tb_top.sv
module sbs_port_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic        core_clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic        burst_mode = 1'b1;
	logic        chip_select_c_n = 1'b0;
	logic [5:0]  addr;
	logic        chip_select_a_n, chip_select_b, burst_advance_n, output_enable_n;
	logic        processor_addr_strobe_n, controller_addr_strobe_n, sleep_request;
	logic        global_write_n, byte_write_enable_n, write_ready, sleep_active;
	logic [3:0]  byte_lane_select_n, parity_in, parity_out, parity_oe_n;
	logic [31:0] data_in, data_out, data_oe_n;
	logic [35:0] mem_m [64];
	int          error_cnt = 0;
	int          checked = 0;
	int          seed = 32'h885d;
	sbs_port #(.ADDR_W(6)) dut (.*);
	sbs_host h (.*);
	always #50 core_clk = !core_clk;
	////////////////////////////////////////////////////////////////
	task automatic chk(input string n, input logic [35:0] seen, input logic [35:0] exp);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task automatic stop_test();
		$display("checked %0d error_cnt %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic rst(input logic m);
		h.cyc(9, 0, 0, 4'hf, 1'b1);
		sys_rst <= 1'b1;
		burst_mode <= m;
		repeat (3) @(posedge core_clk);
		chk("reset outputs", {data_out, write_ready, sleep_active}, 36'h0);
		chk("reset oe_n", {parity_oe_n, data_oe_n}, 36'hf_ffff_ffff);
		sys_rst <= 1'b0;
		@(posedge core_clk);
		@(negedge core_clk);
		chk("write_ready", {35'h0, write_ready}, 36'h1);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		logic [35:0] w;
		logic [3:0]  ln;
		int          ea;
		for (int m = 0; m < 2; m++) begin
			rst(m[0]);
			// Lane selects are noise under global write
			for (int i = 0; i < 12; i++) begin
				w = 36'({$random(seed), $random(seed)});
				h.cyc(2, i, w, 4'($random(seed)), 1'b0);
				mem_m[i] = w;
			end
			for (int i = 8; i < 12; i++) begin
				w = 36'({$random(seed), $random(seed)});
				ln = 4'($random(seed));
				// No lane at all is a read that would drive into the next write
				if (ln == 4'hf) begin
					ln[i % 4] = 1'b0;
				end
				h.cyc(3, i, w, ln, 1'b0);
				for (int b = 0; b < 4; b++)
					if (!ln[b]) begin
						mem_m[i][8 * b +: 8] = w[8 * b +: 8];
						mem_m[i][32 + b] = w[32 + b];
					end
			end
			// Queued writes are invisible to reads, so let the queue drain
			repeat (20) h.cyc(9, 0, 0, 4'hf, 1'b1);
			h.cyc(1, 2, 0, 4'hf, 1'b0);
			repeat (5) h.cyc(8, 0, 0, 4'hf, 1'b1);
			@(negedge core_clk);
			chk("sleep_active", {35'h0, sleep_active}, 36'h1);
			repeat (5) h.cyc(9, 0, 0, 4'hf, 1'b1);
			@(negedge core_clk);
			chk("sleep_active", {35'h0, sleep_active}, 36'h0);
			for (int s = 0; s < 12; s++) begin
				h.cyc(0, 0, 0, 4'hf, 1'b0);
				h.cyc(s % 2 ? 5 : 1, s, 0, 4'hf, s == 5);
				for (int n = 0; n < 4; n++) begin
					h.cyc(n == 1 ? 7 : 4, 0, 0, 4'hf, s == 5);
					@(negedge core_clk);
					ea = (s & ~3) | ((m ? s ^ n : s + n) & 3);
					chk("burst word", {parity_out, data_out}, mem_m[ea]);
					chk("burst oe_n", {parity_oe_n, data_oe_n}, {36{n == 0 || s == 5}});
				end
				h.cyc(6, s, ~mem_m[s], 4'h0, s == 5);
				h.cyc(9, 0, 0, 4'hf, 1'b1);
				@(negedge core_clk);
				chk("both strobes", {parity_out, data_out}, mem_m[s]);
				// Third select off: the strobe deselects instead of starting a read
				h.cyc(1, s, 0, 4'hf, 1'b0);
				chip_select_c_n <= 1'b1;
				h.cyc(4, 0, 0, 4'hf, 1'b0);
				chip_select_c_n <= 1'b0;
				@(negedge core_clk);
				chk("select c off", {parity_oe_n, data_oe_n}, 36'hf_ffff_ffff);
			end
		end
		stop_test();
	end
	initial begin
		#200_000;
		error_cnt++;
		stop_test();
	end
endmodule

bind sbs_port sbs_port_checker chk_i (.core_clk, .sys_rst, .chip_select_a_n, .chip_select_b,
	.chip_select_c_n, .processor_addr_strobe_n, .controller_addr_strobe_n, .global_write_n,
	.byte_write_enable_n, .output_enable_n, .sleep_request, .data_oe_n, .parity_oe_n,
	.sleep_active);
